/* File: pkg/spm_pkg.sv */
// constants and types for the switch power mode controller
package spm_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int NPORT = 2;
  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_SLEEP = 8'h04;
  localparam logic [7:0] ADDR_PORTPD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // field positions
  localparam int MODE_LSB = 3;
  localparam int MODE_MSB = 4;
  localparam int ANEG_BIT = 0;
  localparam logic [7:0] SLEEP_RST = 8'h0f;
  // mode codes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_EDETECT = 2'h1,
    MODE_SOFTPD = 2'h2,
    MODE_SAVE = 2'h3
  } spm_mode_t;
  // energy detect sub-states
  typedef enum logic [1:0] {
    ED_AWAKE = 2'h1,
    ED_ASLEEP = 2'h2
  } spm_ed_t;
  // timing
  localparam int PULSE_NS = 120;
  localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int SLEEP_TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * SLEEP_TICK_MS;
endpackage

/* File: pkg/spm_apb_if.sv */
// apb request and answer bundle between top and register slave
`timescale 1ns/10ps
interface spm_apb_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic err;
  modport master (output wr, output rd, output addr, output wdata, input rdata, input err);
  modport slave (input wr, input rd, input addr, input wdata, output rdata, output err);
endinterface

/* File: rtl/spm_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module spm_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  // first stage read only by second stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

/* File: rtl/spm_regs.sv */
// register file of the power mode controller
`timescale 1ns/10ps
module spm_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  spm_apb_if.slave bus,
  input wire logic [1:0] state_in,
  input wire logic ed_asleep_in,
  input wire logic [1:0] phy_rx_on_in,
  output logic [1:0] mode_out,
  output logic [7:0] sleep_out,
  output logic [spm_pkg::NPORT-1:0] portpd_out,
  output logic aneg_out
);
  logic [1:0] mode_q;
  logic [7:0] sleep_q;
  logic [spm_pkg::NPORT-1:0] portpd_q;
  logic aneg_q;
  logic [31:0] rdata_d;
  logic err_d;
  wire hit_mode = (bus.addr == spm_pkg::ADDR_MODE);
  wire hit_sleep = (bus.addr == spm_pkg::ADDR_SLEEP);
  wire hit_pd = (bus.addr == spm_pkg::ADDR_PORTPD);
  wire hit_st = (bus.addr == spm_pkg::ADDR_STATUS);
  // read mux and unmapped-address error
  always_comb begin
    rdata_d = '0;
    err_d = 1'b0;
    if (hit_mode) begin
      rdata_d[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB] = mode_q;
      rdata_d[spm_pkg::ANEG_BIT] = aneg_q;
    end else if (hit_sleep) begin
      rdata_d[7:0] = sleep_q;
    end else if (hit_pd) begin
      rdata_d[spm_pkg::NPORT-1:0] = portpd_q;
    end else if (hit_st) begin
      rdata_d[1:0] = state_in;
      rdata_d[2] = ed_asleep_in;
      rdata_d[4:3] = phy_rx_on_in;
    end else begin
      err_d = 1'b1;
    end
  end
  assign bus.rdata = rdata_d;
  assign bus.err = err_d;
  // write side; reset returns every field to default
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_q <= spm_pkg::MODE_NORMAL;
      sleep_q <= spm_pkg::SLEEP_RST;
      portpd_q <= '0;
      aneg_q <= 1'b1;
    end else if (ce_in && bus.wr) begin
      if (hit_mode) begin
        mode_q <= bus.wdata[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB];
        aneg_q <= bus.wdata[spm_pkg::ANEG_BIT];
      end else if (hit_sleep) begin
        sleep_q <= bus.wdata[7:0];
      end else if (hit_pd) begin
        portpd_q <= bus.wdata[spm_pkg::NPORT-1:0];
      end
    end
  end
  assign mode_out = mode_q;
  assign sleep_out = sleep_q;
  assign portpd_out = portpd_q;
  assign aneg_out = aneg_q;
endmodule

/* File: rtl/spm_top.sv */
// switch power mode controller top: apb slave, mode sequencing, gating
`timescale 1ns/10ps
module spm_top (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [spm_pkg::NPORT-1:0] ENERGY_IN,
  input wire logic [spm_pkg::NPORT-1:0] CABLE_IN,
  output logic PLL_EN_OUT,
  output logic [spm_pkg::NPORT-1:0] PHY_TX_EN_OUT,
  output logic [spm_pkg::NPORT-1:0] PHY_RX_EN_OUT,
  output logic [spm_pkg::NPORT-1:0] ED_ONLY_OUT,
  output logic MAC_EN_OUT,
  output logic HOST_EN_OUT,
  output logic PKT_EN_OUT,
  output logic [spm_pkg::NPORT-1:0] LINK_PULSE_OUT,
  output logic SOFT_RST_OUT
);
  localparam int NP = spm_pkg::NPORT;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NP-1:0] energy_s;
  logic [NP-1:0] cable_s;
  spm_sync #(.W(2 * NP)) u_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .d_in({ENERGY_IN, CABLE_IN}),
    .q_out({energy_s, cable_s})
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  spm_apb_if bus ();
  logic [1:0] mode;
  logic [7:0] sleep_lim;
  logic [NP-1:0] portpd;
  logic aneg;
  logic soft_rst_q;
  logic asleep_q;
  logic [NP-1:0] rx_on_q;
  wire apb_acc = PSEL_IN && PENABLE_IN;
  wire in_pd = (mode == spm_pkg::MODE_SOFTPD);
  // in power-down an access wakes; its write is dropped until the wake reset, then lands in the last access cycle
  assign bus.wr = apb_acc && PWRITE_IN && !in_pd && CE_IN;
  assign bus.rd = apb_acc && !PWRITE_IN;
  assign bus.addr = PADDR_IN;
  assign bus.wdata = PWDATA_IN;
  // internal reset merges hardware and wake resets
  wire int_rst_n = RST_N_IN && !soft_rst_q;

  spm_regs u_regs (
    .clk_in(CLK_IN),
    .rst_n_in(int_rst_n),
    .ce_in(CE_IN),
    .bus(bus),
    .state_in(mode),
    .ed_asleep_in(asleep_q),
    .phy_rx_on_in(rx_on_q),
    .mode_out(mode),
    .sleep_out(sleep_lim),
    .portpd_out(portpd),
    .aneg_out(aneg)
  );

  // registered apb answer, one wait state
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= '0;
      PSLVERR_OUT <= 1'b0;
    end else if (CE_IN) begin
      PREADY_OUT <= apb_acc && !PREADY_OUT;
      PRDATA_OUT <= (apb_acc && !PREADY_OUT) ? bus.rdata : '0;
      PSLVERR_OUT <= apb_acc && !PREADY_OUT && bus.err;
    end
  end

  // ----------------------------------------
  // wake from soft power-down
  // ----------------------------------------
  // a new access (select rising) while powered down pulses an internal reset;
  // the access that writes the power-down code itself must not wake
  logic psel_q;
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      soft_rst_q <= 1'b0;
      psel_q <= 1'b0;
    end else if (CE_IN) begin
      soft_rst_q <= in_pd && PSEL_IN && !psel_q && !soft_rst_q;
      psel_q <= PSEL_IN;
    end
  end
  assign SOFT_RST_OUT = soft_rst_q;

  // ----------------------------------------
  // energy detect sleep timer
  // ----------------------------------------
  logic [$clog2(spm_pkg::TICK_CYC)-1:0] tick_q;
  logic [7:0] idle_q;
  logic [1:0] ed_q;
  wire ed_mode = (mode == spm_pkg::MODE_EDETECT);
  wire any_energy = |energy_s;
  wire tick = (tick_q == ($clog2(spm_pkg::TICK_CYC))'(spm_pkg::TICK_CYC - 1));
  wire idle_over = (idle_q > sleep_lim);
  always_ff @(posedge CLK_IN) begin
    if (!int_rst_n) begin
      tick_q <= '0;
      idle_q <= '0;
    end else if (CE_IN) begin
      if (!ed_mode || any_energy) begin
        tick_q <= '0;
        idle_q <= '0;
      end else begin
        tick_q <= tick ? '0 : tick_q + 1'b1;
        if (tick && !idle_over) begin
          idle_q <= idle_q + 8'h01;
        end
      end
    end
  end

  // sleep state machine of energy detect mode
  always_ff @(posedge CLK_IN) begin
    if (!int_rst_n) begin
      ed_q <= spm_pkg::ED_AWAKE;
    end else if (CE_IN && !ed_mode) begin
      ed_q <= spm_pkg::ED_AWAKE;
    end else if (CE_IN) begin
      case (ed_q)
        spm_pkg::ED_AWAKE: begin
          if (idle_over && !any_energy) begin
            ed_q <= spm_pkg::ED_ASLEEP;
          end
        end
        spm_pkg::ED_ASLEEP: begin
          if (any_energy) begin
            ed_q <= spm_pkg::ED_AWAKE;
          end
        end
        default: ed_q <= spm_pkg::ED_AWAKE;
      endcase
    end
  end
  wire sleeping = ed_mode && (ed_q == spm_pkg::ED_ASLEEP);

  // ----------------------------------------
  // one pulse per second in energy detect mode
  // ----------------------------------------
  logic [$clog2(spm_pkg::SEC_CYC)-1:0] sec_q;
  wire sec_end = (sec_q == ($clog2(spm_pkg::SEC_CYC))'(spm_pkg::SEC_CYC - 1));
  wire pulse_on = ed_mode && (sec_q < ($clog2(spm_pkg::SEC_CYC))'(spm_pkg::PULSE_CYC));
  always_ff @(posedge CLK_IN) begin
    if (!int_rst_n) begin
      sec_q <= '0;
    end else if (CE_IN && !ed_mode) begin
      sec_q <= '0;
    end else if (CE_IN) begin
      sec_q <= sec_end ? '0 : sec_q + 1'b1;
    end
  end

  // ----------------------------------------
  // power saving receive gating per port
  // ----------------------------------------
  wire save_mode = (mode == spm_pkg::MODE_SAVE);
  // receiver drops only with autoneg on and no cable; energy restores it
  wire [NP-1:0] rx_cut = {NP{save_mode && aneg}} & ~cable_s & ~energy_s;

  // ----------------------------------------
  // block enables, all registered
  // ----------------------------------------
  wire pll_on = (mode == spm_pkg::MODE_NORMAL) || save_mode || (ed_mode && !sleeping);
  wire core_on = !in_pd && !sleeping;
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PLL_EN_OUT <= 1'b1;
      MAC_EN_OUT <= 1'b1;
      HOST_EN_OUT <= 1'b1;
      PKT_EN_OUT <= 1'b1;
      PHY_TX_EN_OUT <= '1;
      PHY_RX_EN_OUT <= '1;
      ED_ONLY_OUT <= '0;
      LINK_PULSE_OUT <= '0;
      asleep_q <= 1'b0;
      rx_on_q <= '1;
    end else if (CE_IN) begin
      PLL_EN_OUT <= pll_on && !in_pd;
      MAC_EN_OUT <= core_on;
      HOST_EN_OUT <= core_on;
      PKT_EN_OUT <= core_on;
      // transmit stays on in saving mode
      PHY_TX_EN_OUT <= {NP{core_on}} & ~portpd;
      PHY_RX_EN_OUT <= {NP{core_on}} & ~portpd & ~rx_cut;
      ED_ONLY_OUT <= {NP{sleeping}} & ~portpd;
      LINK_PULSE_OUT <= {NP{pulse_on}} & ~portpd;
      asleep_q <= sleeping;
      rx_on_q <= {NP{core_on}} & ~portpd & ~rx_cut;
    end
  end
endmodule

/* File: testbench/spm_top_properties.sv */
// port assertions of the power mode controller
`timescale 1ns/10ps
module spm_top_properties (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic PLL_EN_OUT,
  input wire logic [spm_pkg::NPORT-1:0] ED_ONLY_OUT,
  input wire logic MAC_EN_OUT,
  input wire logic HOST_EN_OUT,
  input wire logic PKT_EN_OUT,
  input wire logic [spm_pkg::NPORT-1:0] LINK_PULSE_OUT,
  input wire logic SOFT_RST_OUT
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  chk_ready_one_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT && CE_IN
    |=> PREADY_OUT) else $error("ready late");
  chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held");
  chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("lone slverr");
  chk_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("rdata");
  chk_reset_vals: assert property (disable iff (1'b0) !RST_N_IN |=> PLL_EN_OUT && MAC_EN_OUT
    && HOST_EN_OUT && PKT_EN_OUT && !PREADY_OUT) else $error("reset state");
  chk_sleep_off: assert property (ED_ONLY_OUT != 0 |-> !PLL_EN_OUT && !MAC_EN_OUT
    && !HOST_EN_OUT) else $error("asleep but on");
  chk_pkt_gate: assert property (PKT_EN_OUT |-> MAC_EN_OUT && PLL_EN_OUT && ED_ONLY_OUT == 0)
    else $error("packets while off");
  chk_wake_pulse: assert property (SOFT_RST_OUT |=> !SOFT_RST_OUT ##[0:3] PLL_EN_OUT
    && MAC_EN_OUT) else $error("wake reset");
  chk_link_width: assert property ($rose(LINK_PULSE_OUT[0]) |-> LINK_PULSE_OUT[0] [*5]
    ##1 !LINK_PULSE_OUT[0]) else $error("pulse width");
  cov_sleep: cover property (ED_ONLY_OUT != 0);
  cov_wake: cover property (SOFT_RST_OUT);
  cov_err: cover property (PSLVERR_OUT);
endmodule

/* File: testbench/spm_host.sv */
// apb master model standing in for the host processor
`timescale 1ns/10ps
module spm_host (
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic [31:0] prdata_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // bus idle at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // one transfer; any mode may be written from any state; in soft power-down the access wakes first and the write lands after the wake reset
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule

/* File: testbench/tb_switch_power_mode_control.sv */
// self-checking bench of the power mode controller
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_switch_power_mode_control;
  logic CLK_IN = 1'b0, RST_N_IN = 1'b0, CE_IN = 1'b1;
  logic [1:0] ENERGY_IN = 2'h0, CABLE_IN = 2'h0, TX, RX, EDO, LP;
  logic ps, pe, pw, rdy, err, pll, mac, hst, pkt, srst, e;
  logic [7:0] pa;
  logic [31:0] wd, rd, q;
  int errors = 0, n_compared = 0;
  always #12.5 CLK_IN = ~CLK_IN;
  spm_host host (.clk_in(CLK_IN), .pready_in(rdy), .prdata_in(rd), .pslverr_in(err),
    .psel_out(ps), .penable_out(pe), .pwrite_out(pw), .paddr_out(pa), .pwdata_out(wd));
  spm_top uut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .PSEL_IN(ps),
    .PENABLE_IN(pe), .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(wd), .PRDATA_OUT(rd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err), .ENERGY_IN(ENERGY_IN), .CABLE_IN(CABLE_IN),
    .PLL_EN_OUT(pll), .PHY_TX_EN_OUT(TX), .PHY_RX_EN_OUT(RX), .ED_ONLY_OUT(EDO),
    .MAC_EN_OUT(mac), .HOST_EN_OUT(hst), .PKT_EN_OUT(pkt), .LINK_PULSE_OUT(LP),
    .SOFT_RST_OUT(srst));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] mw(input logic [1:0] m);
    return {27'h0, m, 2'h0, 1'b1};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
    repeat (4) @(posedge CLK_IN);
  endtask
  task automatic rdq(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // defaults after reset
  task automatic t_reset;
    rdq(spm_pkg::ADDR_MODE); `CHK("mode", 32'h1, q)
    rdq(spm_pkg::ADDR_SLEEP); `CHK("sleep", 32'hf, q)
    `CHK("enables", 8'hff, {pll, mac, hst, pkt, TX, RX})
    rdq(8'h10); `CHK("unmapped", 1'b1, e)
  endtask
  // energy detect: sleep with no energy, wake on energy
  task automatic t_edetect;
    int i;
    wr(spm_pkg::ADDR_SLEEP, 32'h0);
    wr(spm_pkg::ADDR_MODE, mw(spm_pkg::MODE_EDETECT));
    rdq(spm_pkg::ADDR_STATUS); `CHK("st mode", 2'h1, q[1:0])
    i = 0;
    while (EDO !== 2'h3 && i < 50000) begin @(posedge CLK_IN); i++; end
    `CHK("asleep", 2'h3, EDO)
    `CHK("off", 8'h00, {pll, mac, hst, pkt, TX, RX})
    ENERGY_IN <= 2'h3;
    repeat (6) @(posedge CLK_IN);
    `CHK("awake", 3'h1, {EDO, pkt})
    ENERGY_IN <= 2'h0;
    wr(spm_pkg::ADDR_MODE, mw(spm_pkg::MODE_NORMAL));
  endtask
  // soft power-down, then a wake access resets registers
  task automatic t_softpd;
    wr(spm_pkg::ADDR_MODE, mw(spm_pkg::MODE_SOFTPD));
    `CHK("pd", 4'h0, {pll, mac, TX})
    rdq(spm_pkg::ADDR_STATUS);
    repeat (4) @(posedge CLK_IN);
    rdq(spm_pkg::ADDR_SLEEP); `CHK("sleep dflt", 32'hf, q)
    rdq(spm_pkg::ADDR_MODE); `CHK("mode dflt", 32'h1, q)
  endtask
  // power saving: receive off without cable, back on with cable
  task automatic t_saving;
    wr(spm_pkg::ADDR_MODE, mw(spm_pkg::MODE_SAVE));
    `CHK("save", 6'h3c, {pll, mac, TX, RX})
    rdq(spm_pkg::ADDR_MODE); `CHK("kept", mw(spm_pkg::MODE_SAVE), q)
    CABLE_IN <= 2'h3;
    repeat (6) @(posedge CLK_IN);
    `CHK("rx back", 2'h3, RX)
    CABLE_IN <= 2'h0;
    wr(spm_pkg::ADDR_MODE, mw(spm_pkg::MODE_NORMAL));
    `CHK("normal", 2'h3, RX)
  endtask
  // single port power-down bit
  task automatic t_portpd;
    wr(spm_pkg::ADDR_PORTPD, 32'h2);
    `CHK("port tx", 2'h1, TX)
    wr(spm_pkg::ADDR_PORTPD, 32'h0);
    `CHK("port up", 2'h3, TX)
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    t_reset;
    t_softpd;
    t_saving;
    t_portpd;
    t_edetect;
    give_verdict;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge CLK_IN);
    errors++;
    give_verdict;
  end
endmodule
bind spm_top spm_top_properties chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PLL_EN_OUT(PLL_EN_OUT),
  .ED_ONLY_OUT(ED_ONLY_OUT), .MAC_EN_OUT(MAC_EN_OUT), .HOST_EN_OUT(HOST_EN_OUT),
  .PKT_EN_OUT(PKT_EN_OUT), .LINK_PULSE_OUT(LINK_PULSE_OUT), .SOFT_RST_OUT(SOFT_RST_OUT));
